// ---- pkg/pmsc_consts.svh ----
// pmsc_consts.svh: offsets, field positions, reset values and timing for the mode status block
// assumes: included by its bare name from the package; the design module only uses its macros
`ifndef PMSC_CONSTS_SVH
`define PMSC_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PMSC_OFS_MODE 4'h0
`define PMSC_OFS_VECT 4'h4
`define PMSC_OFS_PINS 4'h8

// ----------------------------------------
// field positions of the mode status word
// ----------------------------------------
`define PMSC_BIT_PTR_HI 15
`define PMSC_BIT_PTR_LO 7
`define PMSC_BIT_ROM 6
`define PMSC_BIT_RAM_OVERLAY 5
`define PMSC_BIT_ADDRESS_VISIBILITY 4
`define PMSC_BIT_UDRAM 3
`define PMSC_BIT_CLKDIS 2
`define PMSC_BIT_MSAT 1
`define PMSC_BIT_SSAT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define PMSC_PTR_RESET 9'h1ff
`define PMSC_RESET_VECTOR 16'hff80

// ----------------------------------------
// memory map
// ----------------------------------------
`define PMSC_ROM_BASE 16'hc000
`define PMSC_PAGE0_TOP 16'h007f
`define PMSC_LOW_DUAL_ACCESS_RAM_TOP 16'h7fff
`define PMSC_UP_DUAL_ACCESS_RAM_BASE 16'h8000

// ----------------------------------------
// arithmetic limits
// ----------------------------------------
`define PMSC_FRAC_OVF_PROD 32'h40000000
`define PMSC_SAT_POS 32'h7fffffff
`define PMSC_SAT_NEG 32'h80000000

// ----------------------------------------
// timing
// ----------------------------------------
`define PMSC_CLK_HZ 250000000
`define PMSC_CLOCK_OUTPUT_PIN_HZ 62500000
`define PMSC_SYNC_FILL 2'h3

`endif

// ---- pkg/pmsc_pkg.sv ----
// pmsc_pkg: types shared by the mode status block and its bench
// assumes: pmsc_consts.svh sits on the include path
package pmsc_pkg;
    `include "pmsc_consts.svh"

    // ----------------------------------------
    // wishbone classic request and answer
    // ----------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pmsc_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } pmsc_wb_rsp_type;

    // ----------------------------------------
    // mode status word layout, msb first
    // ----------------------------------------
    typedef struct packed {
        logic [8:0] vector_page_pointer;
        logic rom_map_select;
        logic ram_overlay;
        logic address_visibility;
        logic upper_ram_data_map;
        logic clock_output_disable;
        logic multiply_saturate;
        logic store_saturate;
    } pmsc_mode_type;

    // ----------------------------------------
    // memory decode flags for the core
    // ----------------------------------------
    typedef struct packed {
        logic prog_in_rom;
        logic prog_in_dual_access_ram;
        logic data_in_dual_access_ram;
    } pmsc_decode_type;

    typedef enum logic [1:0] {
        PMSC_INIT_SYNC,
        PMSC_INIT_LOAD,
        PMSC_RUN
    } pmsc_init_type;
endpackage : pmsc_pkg

// ---- rtl/pmsc_mode_status.sv ----
// pmsc_mode_status: processor mode status register with its decode, pin and saturation logic
// assumes: core logic on clk_sys drives the address, vector and arithmetic inputs;
// only the rom map pin comes from outside and is synchronised here
//
// How it works
// - hardware reset makes the vector page all ones, reset vector at ff80h
// - bits 15..7 hold a 9-bit page pointer choosing the vector page
// - pointer resets to 1ffh; software reset leaves the pointer alone
// - bit 6 loads the rom pin level at reset; software may change it
// - rom map bit 0 enables on-chip rom in program space, 1 hides it
// - overlay bit resets 0; then dual-access ram is in data space only
// - overlay 1 maps dual-access ram up to 7fffh into program space too, except 0h..7fh
// - visibility 0: address pins keep the last bus address
// - visibility 1: internal program addresses appear on the address pins
// - bit 3 resets 0; when 1 upper ram blocks four..seven appear in data space
// - bit 2 resets 0; when 1 the clock output pin stops and sits high
// - bit 1 with overflow and fractional modes saturates products before accumulate
// - bit 0 saturates accumulator data on store, after the store shift
// - after a pointer write, every vector is fetched from the new page
// - vector slots are four words apart inside the 128-word page
`timescale 1ns/100ps

module pmsc_mode_status
    import pmsc_pkg::*;
#(
    parameter int CLK_HZ = `PMSC_CLK_HZ,
    parameter int CLOCK_OUTPUT_PIN_HZ = `PMSC_CLOCK_OUTPUT_PIN_HZ
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire pmsc_wb_req_type wb_req,
    output pmsc_wb_rsp_type wb_rsp,
    input wire logic rom_map_select_pin,
    input wire logic soft_reset,
    input wire logic [15:0] prog_addr,
    input wire logic prog_addr_valid,
    input wire logic [15:0] data_addr,
    input wire logic [15:0] ext_bus_addr,
    input wire logic ext_bus_valid,
    input wire logic [4:0] vector_num,
    input wire logic vector_req,
    input wire logic overflow_mode,
    input wire logic fractional_mode,
    input wire logic [31:0] product,
    input wire logic product_valid,
    input wire logic [39:0] store_shifted,
    input wire logic store_valid,
    output pmsc_mode_type mode,
    output pmsc_decode_type decode,
    output logic [15:0] address_pins,
    output logic [15:0] vector_addr,
    output logic vector_addr_valid,
    output logic clock_output_pin,
    output logic [31:0] product_out,
    output logic [31:0] store_data,
    output logic store_data_valid
);

    // ----------------------------------------
    // elaboration checks and derived counts
    // ----------------------------------------
    localparam int HALF_CYC = CLK_HZ / (2 * CLOCK_OUTPUT_PIN_HZ);
    localparam int DIV_W = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;

    generate
        if (HALF_CYC < 1) begin : g_bad_div
            $error("clock output rate too high for clk_sys");
        end
        // an uneven ratio would leave the output at the wrong rate
        if (CLK_HZ % (2 * CLOCK_OUTPUT_PIN_HZ) != 0) begin : g_odd_div
            $error("clock output rate must divide clk_sys evenly");
        end
    endgenerate

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] sat40(input logic [39:0] v);
        logic hi_ok;
        hi_ok = (v[39:31] == 9'h000) || (v[39:31] == 9'h1ff);
        if (hi_ok) begin
            sat40 = v[31:0];
        end else if (v[39]) begin
            sat40 = `PMSC_SAT_NEG;
        end else begin
            sat40 = `PMSC_SAT_POS;
        end
    endfunction : sat40

    function automatic logic lane_hit(input logic [3:0] sel, input int lane);
        lane_hit = sel[lane];
    endfunction : lane_hit

    // ----------------------------------------
    // rom pin synchroniser and reset-time capture
    // ----------------------------------------
    logic rom_sync1_q;
    logic rom_sync2_q;
    pmsc_init_type init_q;
    logic [1:0] fill_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rom_sync1_q <= 1'b0;
            rom_sync2_q <= 1'b0;
        end else begin
            rom_sync1_q <= rom_map_select_pin;
            rom_sync2_q <= rom_sync1_q;
        end
    end

    // wait for the synchroniser to fill before trusting the pin
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            init_q <= PMSC_INIT_SYNC;
            fill_q <= 2'h0;
        end else begin
            case (init_q)
                PMSC_INIT_SYNC: begin
                    fill_q <= fill_q + 2'h1;
                    if (fill_q == `PMSC_SYNC_FILL) begin
                        init_q <= PMSC_INIT_LOAD;
                    end
                end
                PMSC_INIT_LOAD: begin
                    init_q <= PMSC_RUN;
                end
                PMSC_RUN: begin
                    init_q <= PMSC_RUN;
                end
                default: begin
                    init_q <= PMSC_INIT_SYNC;
                end
            endcase
        end
    end

    // ----------------------------------------
    // wishbone slave
    // ----------------------------------------
    logic ack_q;
    logic [31:0] rdat_q;
    logic bus_take;
    logic mode_wr;

    // a write lands at the edge that takes it, the same edge that raises ack
    assign bus_take = wb_req.cyc && wb_req.stb && !ack_q;
    assign mode_wr = bus_take && wb_req.we && (wb_req.adr == `PMSC_OFS_MODE);

    pmsc_mode_type mode_q;
    logic [15:0] vect_q;
    logic [15:0] pins_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= bus_take;
            rdat_q <= 32'h00000000;
            if (bus_take && !wb_req.we) begin
                case (wb_req.adr)
                    `PMSC_OFS_MODE: rdat_q <= {16'h0000, mode_q};
                    `PMSC_OFS_VECT: rdat_q <= {16'h0000, vect_q};
                    `PMSC_OFS_PINS: rdat_q <= {16'h0000, pins_q};
                    // unmapped reads answer zero, writes are dropped
                    default: rdat_q <= 32'h00000000;
                endcase
            end
        end
    end

    assign wb_rsp = '{ack: ack_q, dat: rdat_q};

    // ----------------------------------------
    // mode status register
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode_q.vector_page_pointer <= `PMSC_PTR_RESET;
            mode_q.rom_map_select <= 1'b0;
            mode_q.ram_overlay <= 1'b0;
            mode_q.address_visibility <= 1'b0;
            mode_q.upper_ram_data_map <= 1'b0;
            mode_q.clock_output_disable <= 1'b0;
            // cleared only to keep state defined; software must program them
            mode_q.multiply_saturate <= 1'b0;
            mode_q.store_saturate <= 1'b0;
        end else begin
            if (init_q == PMSC_INIT_LOAD) begin
                mode_q.rom_map_select <= rom_sync2_q;
            end
            // software reset leaves pointer and rom bit untouched
            if (soft_reset) begin
                mode_q.ram_overlay <= 1'b0;
                mode_q.address_visibility <= 1'b0;
                mode_q.upper_ram_data_map <= 1'b0;
                mode_q.clock_output_disable <= 1'b0;
            end else if (mode_wr) begin
                if (lane_hit(wb_req.sel, 1)) begin
                    mode_q.vector_page_pointer[8:1] <= wb_req.dat[15:8];
                end
                if (lane_hit(wb_req.sel, 0)) begin
                    mode_q.vector_page_pointer[0] <= wb_req.dat[`PMSC_BIT_PTR_LO];
                    mode_q.rom_map_select <= wb_req.dat[`PMSC_BIT_ROM];
                    mode_q.ram_overlay <= wb_req.dat[`PMSC_BIT_RAM_OVERLAY];
                    mode_q.address_visibility <= wb_req.dat[`PMSC_BIT_ADDRESS_VISIBILITY];
                    mode_q.upper_ram_data_map <= wb_req.dat[`PMSC_BIT_UDRAM];
                    mode_q.clock_output_disable <= wb_req.dat[`PMSC_BIT_CLKDIS];
                    mode_q.multiply_saturate <= wb_req.dat[`PMSC_BIT_MSAT];
                    mode_q.store_saturate <= wb_req.dat[`PMSC_BIT_SSAT];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode <= '0;
        end else begin
            mode <= mode_q;
        end
    end

    // ----------------------------------------
    // memory decode
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            decode <= '0;
        end else begin
            decode.prog_in_rom <= !mode_q.rom_map_select
                && (prog_addr >= `PMSC_ROM_BASE);
            // page 0 stays out of program space even with the overlay on
            decode.prog_in_dual_access_ram <= mode_q.ram_overlay
                && (prog_addr > `PMSC_PAGE0_TOP)
                && (prog_addr <= `PMSC_LOW_DUAL_ACCESS_RAM_TOP);
            decode.data_in_dual_access_ram <= (data_addr > `PMSC_PAGE0_TOP)
                && ((data_addr <= `PMSC_LOW_DUAL_ACCESS_RAM_TOP)
                || (mode_q.upper_ram_data_map
                && (data_addr >= `PMSC_UP_DUAL_ACCESS_RAM_BASE)));
        end
    end

    // ----------------------------------------
    // external address pins
    // ----------------------------------------
    // a real bus cycle always wins over trace output
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pins_q <= 16'h0000;
        end else if (ext_bus_valid) begin
            pins_q <= ext_bus_addr;
        end else if (mode_q.address_visibility && prog_addr_valid) begin
            pins_q <= prog_addr;
        end
    end

    assign address_pins = pins_q;

    // ----------------------------------------
    // vector address
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            vect_q <= `PMSC_RESET_VECTOR;
            vector_addr_valid <= 1'b0;
        end else begin
            vector_addr_valid <= vector_req;
            if (vector_req) begin
                // page base from the live pointer, slot times four
                vect_q <= {mode_q.vector_page_pointer, vector_num, 2'b00};
            end
        end
    end

    assign vector_addr = vect_q;

    // ----------------------------------------
    // clock output divider
    // ----------------------------------------
    logic [DIV_W-1:0] div_q;
    logic div_tick;

    assign div_tick = (div_q == DIV_W'(HALF_CYC - 1));

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            div_q <= '0;
        end else if (div_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clock_output_pin <= 1'b1;
        end else if (mode_q.clock_output_disable) begin
            clock_output_pin <= 1'b1;
        end else if (div_tick) begin
            clock_output_pin <= !clock_output_pin;
        end
    end

    // ----------------------------------------
    // saturation on multiply and on store
    // ----------------------------------------
    // only the fractional -1 * -1 product can overflow the 32-bit result
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            product_out <= 32'h00000000;
        end else if (product_valid) begin
            if (mode_q.multiply_saturate && overflow_mode && fractional_mode
                && (product == `PMSC_FRAC_OVF_PROD)) begin
                product_out <= `PMSC_SAT_POS;
            end else begin
                product_out <= product;
            end
        end
    end

    // input is already shifted, so clamping here follows the shift
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            store_data <= 32'h00000000;
            store_data_valid <= 1'b0;
        end else begin
            store_data_valid <= store_valid;
            if (store_valid) begin
                if (mode_q.store_saturate) begin
                    store_data <= sat40(store_shifted);
                end else begin
                    store_data <= store_shifted[31:0];
                end
            end
        end
    end

endmodule : pmsc_mode_status

// ---- tb/pmsc_mode_status_props.sv ----
// pmsc_mode_status_props: port checks for the mode status block
// assumes: bound to pmsc_mode_status with default parameters
`timescale 1ns/100ps
module pmsc_mode_status_chk
    import pmsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire pmsc_wb_req_type wb_req,
    input wire pmsc_wb_rsp_type wb_rsp,
    input wire logic [4:0] vector_num,
    input wire logic vector_req,
    input wire logic overflow_mode,
    input wire logic fractional_mode,
    input wire logic [31:0] product,
    input wire logic product_valid,
    input wire logic prog_addr_valid,
    input wire logic [15:0] ext_bus_addr,
    input wire logic ext_bus_valid,
    input wire pmsc_mode_type mode,
    input wire logic [15:0] address_pins,
    input wire logic [15:0] vector_addr,
    input wire logic vector_addr_valid,
    input wire logic clock_output_pin,
    input wire logic [31:0] product_out
);
    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // ----
    // relations at the ports
    // ----
    AST_ACK_ONE: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack
        |=> wb_rsp.ack ##1 !wb_rsp.ack) else $error("ack not a single pulse");
    AST_DAT_ZERO: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
        else $error("read data not zero outside ack");
    AST_VEC: assert property (vector_req |=> vector_addr_valid &&
        vector_addr == {mode.vector_page_pointer, $past(vector_num), 2'b00})
        else $error("vector address wrong");
    AST_CLK_HIGH: assert property (mode.clock_output_disable [*2]
        |-> clock_output_pin) else $error("clock pin not held high");
    AST_CLK_RUN: assert property (!mode.clock_output_disable [*6]
        |-> clock_output_pin != $past(clock_output_pin, 2)) else $error("clock pin stuck");
    AST_PROD_SAT: assert property (product_valid && mode.multiply_saturate &&
        overflow_mode && fractional_mode && product == 32'h40000000
        |=> product_out == 32'h7fffffff) else $error("product not saturated");
    AST_PROD_PASS: assert property (product_valid && !mode.multiply_saturate
        |=> product_out == $past(product)) else $error("product altered");
    AST_PINS_EXT: assert property (ext_bus_valid
        |=> address_pins == $past(ext_bus_addr)) else $error("bus address not on pins");
    AST_PINS_HOLD: assert property (!ext_bus_valid && !prog_addr_valid
        |=> $stable(address_pins)) else $error("address pins moved");
    cover property (vector_req);
    cover property (product_valid && mode.multiply_saturate && product == 32'h40000000);
    cover property (mode.clock_output_disable [*2]);
endmodule : pmsc_mode_status_chk

// ---- tb/tb.sv ----
// tb: self-checking bench for the mode status block
// assumes: pmsc_pkg and the checker compile first; default parameters
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    import pmsc_pkg::*;
    logic clk_sys = 0, rstn = 0, rom_map_select_pin = 1, soft_reset = 0;
    pmsc_wb_req_type wb_req = '0;
    pmsc_wb_rsp_type wb_rsp;
    logic prog_addr_valid = 0, ext_bus_valid = 0, vector_req = 0;
    logic product_valid = 0, store_valid = 0, overflow_mode = 0, fractional_mode = 0;
    logic vector_addr_valid, clock_output_pin, store_data_valid, cp;
    logic [15:0] prog_addr = '0, data_addr = '0, ext_bus_addr = '0;
    logic [15:0] address_pins, vector_addr, w, ap_e;
    logic [4:0] vector_num = '0;
    logic [31:0] product = '0, product_out, store_data, rd, pr;
    logic [39:0] store_shifted = '0, st;
    pmsc_mode_type mode;
    pmsc_decode_type decode;
    int n_mismatch = 0, total_checks = 0, seed = 14, i, k, n_chg;
    logic [15:0] ms [2] = '{16'h003b, 16'h0044};
    logic [15:0] cn [4] = '{16'hc000, 16'h007f, 16'h0080, 16'h7fff};
    logic [39:0] sc [3] = '{40'h0080000000, 40'hff7fffffff, 40'h007fffffff};
    always #2 clk_sys = ~clk_sys;
    pmsc_mode_status u_dut (.clk_sys, .rstn, .wb_req, .wb_rsp, .rom_map_select_pin,
        .soft_reset, .prog_addr, .prog_addr_valid, .data_addr, .ext_bus_addr,
        .ext_bus_valid, .vector_num, .vector_req, .overflow_mode, .fractional_mode,
        .product, .product_valid, .store_shifted, .store_valid, .mode, .decode,
        .address_pins, .vector_addr, .vector_addr_valid, .clock_output_pin,
        .product_out, .store_data, .store_data_valid);
    // ----
    // helpers
    // ----
    task automatic tk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tk
    task automatic bus(input logic we, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        wb_req <= '{1'b1, 1'b1, we, a, 4'h3, {16'h0, d}};
        // no cycle budget here: only the watchdog ends a hung wait
        do begin
            @(posedge clk_sys);
        end while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat;
        wb_req <= '0;
    endtask : bus
    function automatic logic [2:0] exp_dec(input logic [15:0] m, pa, da);
        exp_dec[2] = !m[6] && pa >= 16'hc000;
        exp_dec[1] = m[5] && pa >= 16'h0080 && pa <= 16'h7fff;
        exp_dec[0] = (da >= 16'h0080 && da <= 16'h7fff) || (m[3] && da >= 16'h8000);
    endfunction : exp_dec
    function automatic logic [31:0] exp_st(input logic sat, input logic [39:0] v);
        if (sat && $signed(v) > 40'sh007fffffff) return 32'h7fffffff;
        if (sat && $signed(v) < -40'sh0080000000) return 32'h80000000;
        return v[31:0];
    endfunction : exp_st
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    initial begin
        #40000;
        n_mismatch++;
        test_done();
    end
    initial begin
        tk(3);
        rstn <= 1;
        tk(8);
        // pin is sampled at reset only
        rom_map_select_pin <= 0;
        tk(4);
        bus(0, 4'h0, 16'h0);
        `CHK(rd, 32'h0000ffc0)
        `CHK(vector_addr, 16'hff80)
        bus(0, 4'hc, 16'h0);
        `CHK(rd, 32'h0)
        for (i = 0; i < 6; i++) begin
            w = (i == 0) ? 16'h0000 : 16'($random(seed));
            bus(1, 4'h0, w);
            bus(0, 4'h0, 16'h0);
            `CHK(rd, {16'h0, w})
            vector_num <= 5'($random(seed));
            vector_req <= 1;
            @(posedge clk_sys);
            vector_req <= 0;
            @(posedge clk_sys);
            `CHK(vector_addr, {w[15:7], vector_num, 2'b00})
            `CHK(vector_addr_valid, 1'b1)
            soft_reset <= 1;
            @(posedge clk_sys);
            soft_reset <= 0;
            bus(0, 4'h0, 16'h0);
            `CHK(rd, {16'h0, w & 16'hffc3})
            bus(0, 4'h4, 16'h0);
            `CHK(rd, {16'h0, w[15:7], vector_num, 2'b00})
        end
        ap_e = 16'h0000;
        `CHK(address_pins, ap_e)
        for (k = 0; k < 2; k++) begin
            bus(1, 4'h0, ms[k]);
            tk(3);
            `CHK(mode, ms[k])
            for (i = 0; i < 8; i++) begin
                w = (i < 4) ? cn[i] : 16'($random(seed));
                pr = (i < 4) ? 32'h40000000 : $random(seed);
                st = (i < 3) ? sc[i] : {8'($random(seed)), 32'($random(seed))};
                prog_addr <= w;
                data_addr <= (i < 4) ? cn[3 - i] : 16'($random(seed));
                prog_addr_valid <= 1;
                ext_bus_valid <= (i == 5);
                ext_bus_addr <= 16'($random(seed));
                overflow_mode <= i[0];
                fractional_mode <= i[1];
                product <= pr;
                store_shifted <= st;
                product_valid <= 1;
                store_valid <= 1;
                @(posedge clk_sys);
                product_valid <= 0;
                store_valid <= 0;
                ap_e = ext_bus_valid ? ext_bus_addr : (ms[k][4] ? w : ap_e);
                @(posedge clk_sys);
                `CHK(decode, exp_dec(ms[k], prog_addr, data_addr))
                `CHK(address_pins, ap_e)
                `CHK(product_out, (ms[k][1] && i[0] && i[1] && pr == 32'h40000000) ?
                    32'h7fffffff : pr)
                `CHK(store_data, exp_st(ms[k][0], st))
                `CHK(store_data_valid, 1'b1)
            end
            prog_addr_valid <= 0;
            ext_bus_valid <= 0;
            cp = clock_output_pin;
            n_chg = 0;
            for (i = 0; i < 8; i++) begin
                @(posedge clk_sys);
                n_chg += (clock_output_pin !== cp);
                cp = clock_output_pin;
            end
            `CHK(n_chg, ms[k][2] ? 0 : 4)
            bus(0, 4'h8, 16'h0);
            `CHK(rd, {16'h0, ap_e})
        end
        // second hardware reset: pointer back to all ones, rom bit from the low pin
        rstn <= 0;
        tk(2);
        rstn <= 1;
        tk(8);
        `CHK(vector_addr, 16'hff80)
        bus(0, 4'h0, 16'h0);
        `CHK(rd, 32'h0000ff80)
        test_done();
    end
endmodule : tb
bind pmsc_mode_status pmsc_mode_status_chk u_chk (.clk_sys, .rstn, .wb_req, .wb_rsp,
    .vector_num, .vector_req, .overflow_mode, .fractional_mode, .product,
    .product_valid, .prog_addr_valid, .ext_bus_addr, .ext_bus_valid, .mode,
    .address_pins, .vector_addr, .vector_addr_valid, .clock_output_pin, .product_out);
